// >>> mcd_pkg.sv
// Constants, encodings and types shared by the instruction decoder and its ALU.
// Assumes 14-bit instruction words and an 8-bit data path.
//
// Functional notes
// - Every file-register instruction reads its register first
// - Target bit 0 writes accumulator, 1 writes register
// - Register number field is seven bits, 0x00-0x7F
// - Decode add, AND, OR accumulator-with-register forms
// - Carry arithmetic ops update carry, nibble, zero
// - Logical, complement, inc, dec, move: zero only
// - Rotates touch carry; shifts touch carry and zero
// - Accumulator clear ignores its two low bits
// - Dec/inc skip write result, skip on zero
// - Bit clear/set use three-bit position, no flags
// - Bit tests skip on matching bit, no flags
// - Literal add/subtract update carry, nibble, zero
// - Literal AND/OR/XOR write accumulator, zero only
// - Literal loads for pc latch, bank, accumulator
// - Indirect forms carry pointer select and step style
// - Taken skip spends next cycle as no-operation
// - Instruction cycle spans four core clocks
package mcd_pkg;
  localparam int INSTR_W = 14;
  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 7;

  // Instruction fields
  localparam int OPC_HI   = 13;
  localparam int OPC_LO   = 8;
  localparam int DEST_BIT = 7;
  localparam int BPOS_HI  = 9;
  localparam int BPOS_LO  = 7;
  localparam int FADR_HI  = 6;
  localparam int IND_DIR  = 3;
  localparam int IND_PTR  = 2;

  localparam logic [INSTR_W-1:0] NOP_WORD = 14'h0000;

  // Six-bit major opcodes
  localparam logic [5:0] OPC_MISC   = 6'h00;
  localparam logic [5:0] OPC_CLR    = 6'h01;
  localparam logic [5:0] OPC_SUBRA  = 6'h02;
  localparam logic [5:0] OPC_DECF   = 6'h03;
  localparam logic [5:0] OPC_IORWF  = 6'h04;
  localparam logic [5:0] OPC_ANDWF  = 6'h05;
  localparam logic [5:0] OPC_XORWF  = 6'h06;
  localparam logic [5:0] OPC_ADDAR  = 6'h07;
  localparam logic [5:0] OPC_MOVF   = 6'h08;
  localparam logic [5:0] OPC_COMF   = 6'h09;
  localparam logic [5:0] OPC_INCF   = 6'h0A;
  localparam logic [5:0] OPC_DECSK  = 6'h0B;
  localparam logic [5:0] OPC_RRF    = 6'h0C;
  localparam logic [5:0] OPC_RLF    = 6'h0D;
  localparam logic [5:0] OPC_SWAPF  = 6'h0E;
  localparam logic [5:0] OPC_INCSK  = 6'h0F;
  localparam logic [5:0] OPC_MOVLW  = 6'h30;
  localparam logic [5:0] OPC_LDPCL  = 6'h31;
  localparam logic [5:0] OPC_LSLF   = 6'h35;
  localparam logic [5:0] OPC_LSRF   = 6'h36;
  localparam logic [5:0] OPC_ASRF   = 6'h37;
  localparam logic [5:0] OPC_IORLW  = 6'h38;
  localparam logic [5:0] OPC_ANDLW  = 6'h39;
  localparam logic [5:0] OPC_XORLW  = 6'h3A;
  localparam logic [5:0] OPC_SUBBR  = 6'h3B;
  localparam logic [5:0] OPC_SUBLW  = 6'h3C;
  localparam logic [5:0] OPC_ADDCR  = 6'h3D;
  localparam logic [5:0] OPC_ADDLW  = 6'h3E;

  // Bit-oriented group: top two bits, then two-bit kind
  localparam logic [1:0] GRP_BIT  = 2'h1;
  localparam logic [1:0] BK_CLR   = 2'h0;
  localparam logic [1:0] BK_SET   = 2'h1;
  localparam logic [1:0] BK_TLOW  = 2'h2;
  localparam logic [1:0] BK_THIGH = 2'h3;

  // Sub-decodes of the 00 0000 group, bits 7:4 or 7:5
  localparam logic [2:0] MISC_BANK = 3'h1;
  localparam logic [3:0] MISC_IND  = 4'h1;

  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b11,
    PH_Q4 = 2'b10
  } mcd_phase_t;

  typedef enum logic [4:0] {
    ALU_NONE, ALU_ADD, ALU_ADDC, ALU_SUB, ALU_SUBB, ALU_AND, ALU_IOR, ALU_XOR,
    ALU_COM, ALU_DEC, ALU_INC, ALU_MOV, ALU_MOVW, ALU_SWAP, ALU_RLF, ALU_RRF,
    ALU_ASR, ALU_LSL, ALU_LSR, ALU_CLR, ALU_BCLR, ALU_BSET
  } mcd_aluop_t;

  typedef enum logic [1:0] {
    SK_NONE, SK_ZERO, SK_BLOW, SK_BHIGH
  } mcd_skip_t;
endpackage : mcd_pkg

// >>> mcd_alu.sv
// Combinational 8-bit ALU for the instruction decoder.
// Assumes operands are stable for the whole execute phase.
`timescale 1ns/1ps
`default_nettype none
module mcd_alu
  import mcd_pkg::*;
(
  input  wire mcd_aluop_t        op,
  input  wire logic [DATA_W-1:0] a,
  input  wire logic [DATA_W-1:0] w,
  input  wire logic              cin,
  input  wire logic [2:0]        bsel,
  output logic [DATA_W-1:0]      res,
  output logic                   c,
  output logic                   dc,
  output logic                   z,
  output logic                   bit_val
);
  logic [DATA_W-1:0] y;
  logic              ci;
  logic [DATA_W:0]   sum;
  logic [4:0]        lo;
  logic [DATA_W-1:0] mask;

  always_comb begin
    // Subtraction is a + ~w + ci, so carry high means no borrow
    y    = (op == ALU_SUB || op == ALU_SUBB) ? ~w : w;
    ci   = (op == ALU_SUB) ? 1'b1 : (op == ALU_ADDC || op == ALU_SUBB) ? cin : 1'b0;
    sum  = {1'b0, a} + {1'b0, y} + {{DATA_W{1'b0}}, ci};
    lo   = {1'b0, a[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
    mask = 8'h01 << bsel;
    c    = cin;
    dc   = lo[4];
    unique case (op)
      ALU_ADD, ALU_ADDC, ALU_SUB, ALU_SUBB: begin
        res = sum[DATA_W-1:0];
        c   = sum[DATA_W];
      end
      ALU_AND:  res = a & w;
      ALU_IOR:  res = a | w;
      ALU_XOR:  res = a ^ w;
      ALU_COM:  res = ~a;
      ALU_DEC:  res = a - 8'h01;
      ALU_INC:  res = a + 8'h01;
      ALU_MOVW: res = w;
      ALU_SWAP: res = {a[3:0], a[7:4]};
      ALU_RLF: begin
        res = {a[6:0], cin};
        c   = a[7];
      end
      ALU_RRF: begin
        res = {cin, a[7:1]};
        c   = a[0];
      end
      ALU_ASR: begin
        res = {a[7], a[7:1]};
        c   = a[0];
      end
      ALU_LSL: begin
        res = {a[6:0], 1'b0};
        c   = a[7];
      end
      ALU_LSR: begin
        res = {1'b0, a[7:1]};
        c   = a[0];
      end
      ALU_CLR:  res = 8'h00;
      ALU_BCLR: res = a & ~mask;
      ALU_BSET: res = a | mask;
      default:  res = a;
    endcase
    z       = (res == 8'h00);
    bit_val = a[bsel];
  end
endmodule : mcd_alu
`default_nettype wire

// >>> mcd_decoder.sv
// Decode and execute stage: four-phase instruction cycle, file-register
// read-modify-write, accumulator, status flags and literal latches.
// Assumes a file register read returns data one clock after reg_rd_en.
`timescale 1ns/1ps
`default_nettype none
module mcd_decoder
  import mcd_pkg::*;
#(
  parameter int PCL_W  = 7,
  parameter int BANK_W = 5
)(
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic [INSTR_W-1:0] instr,
  input  wire logic               instr_valid,
  output logic                    instr_ready,
  output logic [ADDR_W-1:0]       reg_addr,
  output logic                    reg_rd_en,
  input  wire logic [DATA_W-1:0]  reg_rd_data,
  output logic                    reg_wr_en,
  output logic [DATA_W-1:0]       reg_wr_data,
  output logic [DATA_W-1:0]       accumulator,
  output logic                    carry,
  output logic                    nibble_overflow_bit,
  output logic                    zero,
  output logic [PCL_W-1:0]        upper_pc_latch,
  output logic [BANK_W-1:0]       memory_bank_select,
  output logic                    skip_taken,
  output logic                    indir_strobe,
  output logic                    indir_write,
  output logic                    indir_ptr,
  output logic [1:0]              ptr_step_style,
  output logic                    undefined_op
);
  if (PCL_W < 1 || PCL_W > DEST_BIT || BANK_W < 1 || BANK_W > 5) begin : g_bad
    $error("mcd_decoder: latch widths out of range");
  end

  mcd_phase_t        phase, next_phase;
  logic [INSTR_W-1:0] ir, next_ir;
  logic [ADDR_W-1:0] next_reg_addr;
  logic              skip_pend, next_skip_pend;

  // Decoded controls of the held instruction
  mcd_aluop_t dop;
  mcd_skip_t  dskip;
  logic       use_lit, names_file, wr_w, wr_f, upd_c, upd_dc, upd_z;
  logic       ld_pcl, ld_bank, is_ind, undef;
  logic [5:0] opc;

  assign opc = ir[OPC_HI:OPC_LO];

  // A file-register op with a target select bit
  function automatic logic has_dest(input logic [5:0] o);
    has_dest = (o >= OPC_SUBRA && o <= OPC_INCSK) || o == OPC_LSLF ||
               o == OPC_LSRF || o == OPC_ASRF || o == OPC_SUBBR || o == OPC_ADDCR;
  endfunction : has_dest

  always_comb begin
    dop = ALU_NONE; dskip = SK_NONE; use_lit = 1'b0; names_file = 1'b0;
    wr_w = 1'b0; wr_f = 1'b0; upd_c = 1'b0; upd_dc = 1'b0; upd_z = 1'b0;
    ld_pcl = 1'b0; ld_bank = 1'b0; is_ind = 1'b0; undef = 1'b0;
    if (has_dest(opc)) begin
      names_file = 1'b1;
      wr_w = ~ir[DEST_BIT];
      wr_f = ir[DEST_BIT];
      upd_z = 1'b1;
      unique case (opc)
        OPC_ADDAR:  begin dop = ALU_ADD;  upd_c = 1'b1; upd_dc = 1'b1; end
        OPC_ADDCR:  begin dop = ALU_ADDC; upd_c = 1'b1; upd_dc = 1'b1; end
        OPC_SUBRA:  begin dop = ALU_SUB;  upd_c = 1'b1; upd_dc = 1'b1; end
        OPC_SUBBR:  begin dop = ALU_SUBB; upd_c = 1'b1; upd_dc = 1'b1; end
        OPC_ANDWF:  dop = ALU_AND;
        OPC_IORWF:  dop = ALU_IOR;
        OPC_XORWF:  dop = ALU_XOR;
        OPC_COMF:   dop = ALU_COM;
        OPC_DECF:   dop = ALU_DEC;
        OPC_INCF:   dop = ALU_INC;
        OPC_MOVF:   dop = ALU_MOV;
        OPC_RLF:    begin dop = ALU_RLF; upd_c = 1'b1; upd_z = 1'b0; end
        OPC_RRF:    begin dop = ALU_RRF; upd_c = 1'b1; upd_z = 1'b0; end
        OPC_ASRF:   begin dop = ALU_ASR; upd_c = 1'b1; end
        OPC_LSLF:   begin dop = ALU_LSL; upd_c = 1'b1; end
        OPC_LSRF:   begin dop = ALU_LSR; upd_c = 1'b1; end
        OPC_SWAPF:  begin dop = ALU_SWAP; upd_z = 1'b0; end
        OPC_DECSK:  begin dop = ALU_DEC; upd_z = 1'b0; dskip = SK_ZERO; end
        OPC_INCSK:  begin dop = ALU_INC; upd_z = 1'b0; dskip = SK_ZERO; end
        default:    undef = 1'b1;
      endcase
    end else if (ir[OPC_HI -: 2] == GRP_BIT) begin
      names_file = 1'b1;
      unique case (ir[OPC_HI-2 -: 2])
        BK_CLR:   begin dop = ALU_BCLR; wr_f = 1'b1; end
        BK_SET:   begin dop = ALU_BSET; wr_f = 1'b1; end
        BK_TLOW:  dskip = SK_BLOW;
        BK_THIGH: dskip = SK_BHIGH;
      endcase
    end else if (opc == OPC_CLR) begin
      if (ir[DEST_BIT]) begin
        names_file = 1'b1;
        dop = ALU_CLR; wr_f = 1'b1; upd_z = 1'b1;
      end else if (ir[DEST_BIT-1:2] == '0) begin
        dop = ALU_CLR; wr_w = 1'b1; upd_z = 1'b1;
      end else begin
        undef = 1'b1;
      end
    end else if (opc == OPC_MISC) begin
      if (ir[DEST_BIT]) begin
        names_file = 1'b1;
        dop = ALU_MOVW; wr_f = 1'b1;
      end else if (ir[DEST_BIT -: 3] == MISC_BANK) begin
        ld_bank = 1'b1;
      end else if (ir[DEST_BIT -: 4] == MISC_IND) begin
        is_ind = 1'b1;
      end
      // Remaining encodings are control or inherent ops handled elsewhere
    end else begin
      use_lit = 1'b1;
      wr_w = 1'b1;
      unique case (opc)
        OPC_ADDLW: begin dop = ALU_ADD; upd_c = 1'b1; upd_dc = 1'b1; upd_z = 1'b1; end
        OPC_SUBLW: begin dop = ALU_SUB; upd_c = 1'b1; upd_dc = 1'b1; upd_z = 1'b1; end
        OPC_ANDLW: begin dop = ALU_AND; upd_z = 1'b1; end
        OPC_IORLW: begin dop = ALU_IOR; upd_z = 1'b1; end
        OPC_XORLW: begin dop = ALU_XOR; upd_z = 1'b1; end
        OPC_MOVLW: dop = ALU_MOV;
        OPC_LDPCL: begin
          wr_w = 1'b0;
          ld_pcl = ir[DEST_BIT];
          undef = ~ir[DEST_BIT];
        end
        default: begin
          wr_w = 1'b0;
          undef = 1'b1;
        end
      endcase
    end
  end

  // Sequencing: one instruction per four clocks
  always_comb begin
    next_phase     = phase;
    next_ir        = ir;
    next_reg_addr  = reg_addr;
    next_skip_pend = skip_pend;
    unique case (phase)
      PH_Q1: begin
        next_phase = PH_Q2;
        // The word after a taken skip is consumed and run as a no-operation
        next_ir = (instr_valid && !skip_pend) ? instr : NOP_WORD;
        // Address follows the word really held, so a dropped word names nothing
        next_reg_addr = next_ir[FADR_HI:0];
        next_skip_pend = 1'b0;
      end
      PH_Q2: next_phase = PH_Q3;
      PH_Q3: next_phase = PH_Q4;
      PH_Q4: begin
        next_phase = PH_Q1;
        next_skip_pend = skip_taken;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase     <= PH_Q1;
      ir        <= NOP_WORD;
      reg_addr  <= '0;
      skip_pend <= 1'b0;
    end else begin
      phase     <= next_phase;
      ir        <= next_ir;
      reg_addr  <= next_reg_addr;
      skip_pend <= next_skip_pend;
    end
  end

  assign instr_ready = (phase == PH_Q1);
  assign reg_rd_en   = (phase == PH_Q2) && names_file;
  assign reg_wr_en   = (phase == PH_Q4) && wr_f;
  assign indir_strobe = (phase == PH_Q4) && is_ind;
  assign indir_write  = ir[IND_DIR];
  assign indir_ptr    = ir[IND_PTR];
  assign ptr_step_style = ir[1:0];
  assign undefined_op = (phase == PH_Q4) && undef;

  // Datapath: ALU in the third phase, commit in the fourth
  logic [DATA_W-1:0] alu_res, res, next_res, next_acc;
  logic              alu_c, alu_dc, alu_z, alu_bit;
  logic              res_c, res_dc, res_z, res_bit;
  logic              next_res_c, next_res_dc, next_res_z, next_res_bit;
  logic              next_c, next_dc, next_z;
  logic [PCL_W-1:0]  next_pcl;
  logic [BANK_W-1:0] next_bank;

  mcd_alu u_alu (
    .op      (dop),
    .a       (use_lit ? ir[DATA_W-1:0] : reg_rd_data),
    .w       (accumulator),
    .cin     (carry),
    .bsel    (ir[BPOS_HI:BPOS_LO]),
    .res     (alu_res),
    .c       (alu_c),
    .dc      (alu_dc),
    .z       (alu_z),
    .bit_val (alu_bit)
  );

  always_comb begin
    next_res = res; next_res_c = res_c; next_res_dc = res_dc;
    next_res_z = res_z; next_res_bit = res_bit;
    next_acc = accumulator; next_c = carry; next_dc = nibble_overflow_bit;
    next_z = zero; next_pcl = upper_pc_latch; next_bank = memory_bank_select;
    if (phase == PH_Q3) begin
      next_res = alu_res; next_res_c = alu_c; next_res_dc = alu_dc;
      next_res_z = alu_z; next_res_bit = alu_bit;
    end
    if (phase == PH_Q4) begin
      if (wr_w) next_acc = res;
      if (upd_c) next_c = res_c;
      if (upd_dc) next_dc = res_dc;
      if (upd_z) next_z = res_z;
      if (ld_pcl) next_pcl = ir[PCL_W-1:0];
      if (ld_bank) next_bank = ir[BANK_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      res <= '0; res_c <= 1'b0; res_dc <= 1'b0; res_z <= 1'b0; res_bit <= 1'b0;
      accumulator <= '0; carry <= 1'b0; nibble_overflow_bit <= 1'b0; zero <= 1'b0;
      upper_pc_latch <= '0; memory_bank_select <= '0;
    end else begin
      res <= next_res; res_c <= next_res_c; res_dc <= next_res_dc;
      res_z <= next_res_z; res_bit <= next_res_bit;
      accumulator <= next_acc; carry <= next_c; nibble_overflow_bit <= next_dc;
      zero <= next_z; upper_pc_latch <= next_pcl; memory_bank_select <= next_bank;
    end
  end

  assign reg_wr_data = res;
  always_comb begin
    unique case (dskip)
      SK_ZERO:  skip_taken = (phase == PH_Q4) && res_z;
      SK_BLOW:  skip_taken = (phase == PH_Q4) && !res_bit;
      SK_BHIGH: skip_taken = (phase == PH_Q4) && res_bit;
      default:  skip_taken = 1'b0;
    endcase
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_cycle;
    phase == PH_Q1 ##1 phase == PH_Q2 ##1 phase == PH_Q3 ##1 phase == PH_Q4;
  endsequence
  phase_order_a: assert property (phase == PH_Q1 |-> s_cycle ##1 phase == PH_Q1)
    else $error("instruction cycle is not four clocks");
  read_first_a: assert property (reg_wr_en |-> $past(reg_rd_en, 2))
    else $error("file write without prior read");
  dest_sel_a: assert property (phase == PH_Q4 && has_dest(opc) |-> reg_wr_en == ir[DEST_BIT])
    else $error("target select not honoured");
  addr_field_a: assert property (phase == PH_Q2 |-> reg_addr == ir[FADR_HI:0])
    else $error("register number mismatch");
  swap_flags_a: assert property (phase == PH_Q4 && dop == ALU_SWAP
      |=> carry == $past(carry) && zero == $past(zero))
    else $error("swap changed flags");
  logic_carry_a: assert property (phase == PH_Q4 && (dop == ALU_AND || dop == ALU_XOR)
      |=> carry == $past(carry) && nibble_overflow_bit == $past(nibble_overflow_bit))
    else $error("logical op changed carry");
  rotate_zero_a: assert property (phase == PH_Q4 && (dop == ALU_RLF || dop == ALU_RRF)
      |=> zero == $past(zero))
    else $error("rotate changed zero");
  skip_nop_a: assert property (skip_taken |-> ##2 ir == NOP_WORD ##2 !reg_wr_en)
    else $error("skipped word was executed");
  bit_flags_a: assert property (phase == PH_Q4 && (dop == ALU_BCLR || dop == ALU_BSET)
      |=> zero == $past(zero) && carry == $past(carry))
    else $error("bit op changed flags");
  clrf_zero_a: assert property (phase == PH_Q4 && dop == ALU_CLR |=> zero)
    else $error("clear did not set zero");
  undef_hold_a: assert property (undefined_op
      |=> accumulator == $past(accumulator) && zero == $past(zero))
    else $error("undefined op changed state");
endmodule : mcd_decoder
`default_nettype wire

// >>> mcd_regfile_model.sv
// File-register partner model: a 128-byte store behind the decoder's file port.
// Assumes one read request per instruction, answered on the following clock.
`timescale 1ns/1ps
`default_nettype none
module mcd_regfile_model
  import mcd_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic              reg_rd_en,
  output logic [DATA_W-1:0]      reg_rd_data,
  input  wire logic              reg_wr_en,
  input  wire logic [DATA_W-1:0] reg_wr_data
);
  logic [DATA_W-1:0] mem [128];
  logic [DATA_W-1:0] q = 8'h00;

  // Data is good only in the cycle after a request; inverting it afterwards
  // keeps a late sample from matching by luck.
  always @(posedge clk) begin
    if (reg_rd_en) begin
      q <= mem[reg_addr];
    end else begin
      q <= ~q;
    end
    if (reg_wr_en) begin
      mem[reg_addr] <= reg_wr_data;
    end
  end

  assign reg_rd_data = q;
endmodule : mcd_regfile_model
`default_nettype wire

// >>> mcd_decoder_tb.sv
// Self-checking bench for the decoder: feeds words, checks state and pulses.
// Assumes the file-register model and the package compiled before it.
`timescale 1ns/1ps
`default_nettype none
module mcd_decoder_tb
  import mcd_pkg::*;
;
  localparam logic [ADDR_W-1:0]  FA = 7'h25;
  localparam logic [INSTR_W-1:0] N  = NOP_WORD;

  logic                 clk = 1'b0;
  logic                 rstn = 1'b0;
  logic [INSTR_W-1:0]   instr = NOP_WORD;
  logic                 instr_valid = 1'b0;
  logic                 instr_ready;
  logic [ADDR_W-1:0]    reg_addr;
  logic                 reg_rd_en;
  logic [DATA_W-1:0]    reg_rd_data;
  logic                 reg_wr_en;
  logic [DATA_W-1:0]    reg_wr_data;
  logic [DATA_W-1:0]    accumulator;
  logic                 carry;
  logic                 nibble_overflow_bit;
  logic                 zero;
  logic [6:0]           upper_pc_latch;
  logic [4:0]           memory_bank_select;
  logic                 skip_taken;
  logic                 indir_strobe;
  logic                 indir_write;
  logic                 indir_ptr;
  logic [1:0]           ptr_step_style;
  logic                 undefined_op;
  logic [4:0]           pul;
  int                   failures = 0;
  int                   check_count = 0;

  mcd_decoder uut (.clk(clk), .rstn(rstn), .instr(instr), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .reg_addr(reg_addr), .reg_rd_en(reg_rd_en),
    .reg_rd_data(reg_rd_data), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .accumulator(accumulator), .carry(carry), .nibble_overflow_bit(nibble_overflow_bit),
    .zero(zero), .upper_pc_latch(upper_pc_latch), .memory_bank_select(memory_bank_select),
    .skip_taken(skip_taken), .indir_strobe(indir_strobe), .indir_write(indir_write),
    .indir_ptr(indir_ptr), .ptr_step_style(ptr_step_style), .undefined_op(undefined_op));

  mcd_regfile_model mdl (.clk(clk), .reg_addr(reg_addr), .reg_rd_en(reg_rd_en),
    .reg_rd_data(reg_rd_data), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data));

  initial begin
    forever #2 clk = ~clk;
  end

  function automatic logic [13:0] fr(input logic [5:0] o, input int d);
    return {o, d[0], FA};
  endfunction : fr

  function automatic logic [13:0] lt(input logic [5:0] o, input logic [7:0] k);
    return {o, k};
  endfunction : lt

  function automatic logic [13:0] bt(input logic [1:0] k, input logic [2:0] p);
    return {GRP_BIT, k, p, FA};
  endfunction : bt

  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic test_done();
    if (failures == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  // Word w is taken at the next Q1 edge; nx waits behind it for the
  // following Q1, so a skip must discard it.
  task automatic exec(input logic [13:0] w, input logic [13:0] nx);
    int i;
    @(posedge clk);
    instr <= w;
    instr_valid <= 1'b1;
    @(negedge clk);
    for (i = 0; i < 8 && instr_ready !== 1'b1; i++) @(negedge clk);
    chk("ready", {7'h00, instr_ready}, 8'h01);
    @(posedge clk);
    instr <= nx;
    @(negedge clk);
    pul[4] = reg_rd_en;
    @(negedge clk);
    @(negedge clk);
    pul[3:0] = {reg_wr_en, skip_taken, undefined_op, indir_strobe};
    @(negedge clk);
  endtask : exec

  // Pulse order: read, write, skip, undefined, indirect strobe
  task automatic t(input logic [13:0] w, input logic [13:0] nx, input logic [7:0] ea,
                   input logic [2:0] ef, input logic [7:0] em, input logic [4:0] ep);
    exec(w, nx);
    chk("accumulator", accumulator, ea);
    chk("flags", {5'h00, carry, nibble_overflow_bit, zero}, {5'h00, ef});
    chk("file", mdl.mem[FA], em);
    chk("pulses", {3'h0, pul}, {3'h0, ep});
  endtask : t

  initial begin
    #40000;
    failures++;
    test_done();
  end

  initial begin
    mdl.mem[FA] = 8'h3C;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t(lt(OPC_MOVLW, 8'h0F), N, 8'h0F, 3'b000, 8'h3C, 5'b00000);
    t(fr(OPC_ADDAR, 1), N, 8'h0F, 3'b010, 8'h4B, 5'b11000);
    t(fr(OPC_ADDAR, 0), N, 8'h5A, 3'b010, 8'h4B, 5'b10000);
    t(fr(OPC_SUBRA, 0), N, 8'hF1, 3'b010, 8'h4B, 5'b10000);
    t(fr(OPC_ANDWF, 1), N, 8'hF1, 3'b010, 8'h41, 5'b11000);
    t(fr(OPC_XORWF, 0), N, 8'hB0, 3'b010, 8'h41, 5'b10000);
    t(fr(OPC_IORWF, 1), N, 8'hB0, 3'b010, 8'hF1, 5'b11000);
    t(fr(OPC_COMF, 1), N, 8'hB0, 3'b010, 8'h0E, 5'b11000);
    t(fr(OPC_SWAPF, 0), N, 8'hE0, 3'b010, 8'h0E, 5'b10000);
    t(lt(OPC_ADDLW, 8'h20), N, 8'h00, 3'b101, 8'h0E, 5'b00000);
    t(fr(OPC_RLF, 1), N, 8'h00, 3'b001, 8'h1D, 5'b11000);
    t(fr(OPC_RRF, 1), N, 8'h00, 3'b101, 8'h0E, 5'b11000);
    t(fr(OPC_ADDCR, 0), N, 8'h0F, 3'b000, 8'h0E, 5'b10000);
    t(fr(OPC_SUBBR, 1), N, 8'h0F, 3'b000, 8'hFE, 5'b11000);
    t(fr(OPC_LSLF, 1), N, 8'h0F, 3'b100, 8'hFC, 5'b11000);
    t(fr(OPC_LSRF, 0), N, 8'h7E, 3'b000, 8'hFC, 5'b10000);
    t(fr(OPC_ASRF, 1), N, 8'h7E, 3'b000, 8'hFE, 5'b11000);
    t(fr(OPC_DECF, 1), N, 8'h7E, 3'b000, 8'hFD, 5'b11000);
    t(fr(OPC_INCF, 0), N, 8'hFE, 3'b000, 8'hFD, 5'b10000);
    t(fr(OPC_MOVF, 0), N, 8'hFD, 3'b000, 8'hFD, 5'b10000);
    t(lt(OPC_SUBLW, 8'hFD), N, 8'h00, 3'b111, 8'hFD, 5'b00000);
    t(lt(OPC_XORLW, 8'h5A), N, 8'h5A, 3'b110, 8'hFD, 5'b00000);
    t(fr(OPC_MISC, 1), N, 8'h5A, 3'b110, 8'h5A, 5'b11000);
    t(lt(OPC_ANDLW, 8'h0F), N, 8'h0A, 3'b110, 8'h5A, 5'b00000);
    t(lt(OPC_IORLW, 8'h30), N, 8'h3A, 3'b110, 8'h5A, 5'b00000);
    t({OPC_CLR, 1'b0, 7'h03}, N, 8'h00, 3'b111, 8'h5A, 5'b00000);
    t(lt(OPC_IORLW, 8'h01), N, 8'h01, 3'b110, 8'h5A, 5'b00000);
    t(fr(OPC_CLR, 1), N, 8'h01, 3'b111, 8'h00, 5'b11000);
    t(fr(OPC_DECSK, 1), lt(OPC_MOVLW, 8'h55), 8'h01, 3'b111, 8'hFF, 5'b11000);
    t(N, N, 8'h55, 3'b111, 8'hFF, 5'b00000);
    t(fr(OPC_INCSK, 1), lt(OPC_MOVLW, 8'h66), 8'h55, 3'b111, 8'h00, 5'b11100);
    t(N, N, 8'h55, 3'b111, 8'h00, 5'b00000);
    t(bt(BK_SET, 3'h7), N, 8'h55, 3'b111, 8'h80, 5'b11000);
    t(bt(BK_TLOW, 3'h7), lt(OPC_MOVLW, 8'h77), 8'h55, 3'b111, 8'h80, 5'b10000);
    t(bt(BK_THIGH, 3'h7), lt(OPC_MOVLW, 8'h11), 8'h77, 3'b111, 8'h80, 5'b10100);
    t(bt(BK_CLR, 3'h7), N, 8'h77, 3'b111, 8'h00, 5'b11000);
    t(14'h2000, N, 8'h77, 3'b111, 8'h00, 5'b00010);
    t({OPC_LDPCL, 1'b1, 7'h55}, N, 8'h77, 3'b111, 8'h00, 5'b00000);
    chk("pc latch", {1'b0, upper_pc_latch}, 8'h55);
    t({OPC_LDPCL, 1'b0, 7'h2A}, N, 8'h77, 3'b111, 8'h00, 5'b00010);
    chk("pc latch", {1'b0, upper_pc_latch}, 8'h55);
    t({OPC_MISC, MISC_BANK, 5'h15}, N, 8'h77, 3'b111, 8'h00, 5'b00000);
    chk("bank", {3'h0, memory_bank_select}, 8'h15);
    t({OPC_MISC, MISC_IND, 4'hB}, N, 8'h77, 3'b111, 8'h00, 5'b00001);
    chk("indirect", {4'h0, indir_write, indir_ptr, ptr_step_style}, 8'h0B);
    t({OPC_MISC, MISC_IND, 4'h6}, N, 8'h77, 3'b111, 8'h00, 5'b00001);
    chk("indirect", {4'h0, indir_write, indir_ptr, ptr_step_style}, 8'h06);
    t({OPC_MISC, 1'b1, 7'h7F}, N, 8'h77, 3'b111, 8'h00, 5'b11000);
    chk("file top", mdl.mem[7'h7F], 8'h77);
    test_done();
  end
endmodule : mcd_decoder_tb
`default_nettype wire
